//--- hdl/pwu_pkg.sv
// pwu_pkg: constants, modes and carrier types of the pwm parameter update block
// assumes a 32-bit register port with byte offsets and one system clock
package pwu_pkg;
   // geometry
   localparam int PWU_NCH = 4;
   localparam int PWU_CW  = 16;
   localparam int PWU_AW  = 8;
   localparam int PWU_DW  = 32;

   // register offsets
   localparam logic [7:0] PWU_ENA_OFF  = 8'h00; // channel_enable_reg, write 1 starts
   localparam logic [7:0] PWU_DIS_OFF  = 8'h04; // write 1 stops
   localparam logic [7:0] PWU_CHSR_OFF = 8'h08; // enabled channels
   localparam logic [7:0] PWU_SCM_OFF  = 8'h0C; // sync_channels_mode_reg
   localparam logic [7:0] PWU_SCUC_OFF = 8'h10; // sync_update_control_reg
   localparam logic [7:0] PWU_SCUP_OFF = 8'h14; // sync_update_period_reg
   localparam logic [7:0] PWU_IEN1_OFF = 8'h18; // irq_enable_first
   localparam logic [7:0] PWU_ICL1_OFF = 8'h1C; // first clear, write-only
   localparam logic [7:0] PWU_IST1_OFF = 8'h20; // first status, read-only
   localparam logic [7:0] PWU_IEN2_OFF = 8'h24; // irq_enable_second
   localparam logic [7:0] PWU_ICL2_OFF = 8'h28; // second clear, write-only
   localparam logic [7:0] PWU_IST2_OFF = 8'h2C; // second status, read-only
   localparam logic [7:0] PWU_PEND_OFF = 8'h30; // pending shadow flags
   localparam logic [7:0] PWU_CH_BASE  = 8'h40;
   localparam logic [7:0] PWU_CH_STEP  = 8'h10;
   localparam logic [7:0] PWU_PRD_OFF  = 8'h00; // period_shadow_reg / active period
   localparam logic [7:0] PWU_DTY_OFF  = 8'h04; // duty_shadow_reg / active duty
   localparam logic [7:0] PWU_DT_OFF   = 8'h08; // deadtime_shadow_reg / active dead time

   // field positions
   localparam int PWU_SYNC_UPDATE_METHOD_LSB   = 16;
   localparam int PWU_UNLOCK_BIT = 0;
   localparam int PWU_UPR_W      = 4;
   localparam int PWU_UPDATE_PERIOD_COUNTER_LSB = 8;
   localparam int PWU_FAULT_LSB  = 16;
   localparam int PWU_IRQ1_W     = 32;
   localparam int PWU_IRQ2_W     = 4;
   localparam int PWU_WRITE_READY_FLAG_BIT   = 0;
   localparam int PWU_UNDERRUN_FLAG_BIT   = 3;
   localparam int PWU_PEND_DTY   = 8;
   localparam int PWU_PEND_DT    = 16;

   // reset values
   localparam logic [PWU_CW-1:0] PWU_PRM_RST = 16'h0000;

   // sync update methods
   typedef enum logic [1:0] {
      PWU_UPD_MANUAL,
      PWU_UPD_AUTO,
      PWU_UPD_DMA
   } pwu_sync_update_method_t;

   // one channel's waveform parameters
   typedef struct packed {
      logic [PWU_CW-1:0] prd;
      logic [PWU_CW-1:0] dty;
      logic [PWU_CW-1:0] dt;
   } pwu_prm_t;
endpackage

//--- hdl/pwu_cnt.sv
// pwu_cnt: one channel period counter with high and low side outputs
// assumes parameters change only on the edge where end_o is high
`timescale 1ns/1ps
module pwu_cnt
   import pwu_pkg::*;
#(
   parameter int CW = PWU_CW
) (
   input  wire logic           clk_i,   // system clock
   input  wire logic           rst_n_i, // async reset, low
   input  wire logic           en_i,    // channel running
   input  wire pwu_prm_t       prm_i,   // active parameters
   output logic                end_o,   // last count of period
   output logic                hi_o,    // high side, registered
   output logic                lo_o     // low side, registered
);
   logic [CW-1:0] cnt_r;
   logic [CW:0]   lo_edge;

   // wrap at period minus one; period zero wraps each cycle
   assign end_o   = en_i && ((prm_i.prd == '0) || (cnt_r == prm_i.prd - 1'b1));
   assign lo_edge = {1'b0, prm_i.dty} + {1'b0, prm_i.dt};

   // period counter
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cnt_r <= '0;
      end else if (!en_i || end_o) begin
         cnt_r <= '0;
      end else begin
         cnt_r <= cnt_r + 1'b1;
      end
   end

   // duty in whole counts of the period
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         hi_o <= 1'b0;
         lo_o <= 1'b0;
      end else begin
         hi_o <= en_i && (cnt_r >= prm_i.dt) && (cnt_r < prm_i.dty);
         lo_o <= en_i && ({1'b0, cnt_r} >= lo_edge);
      end
   end
endmodule // pwu_cnt

//--- hdl/pwu_irq.sv
// pwu_irq: sticky status, enable mask and level interrupt for one group
// assumes events are one-cycle pulses on the system clock
`timescale 1ns/1ps
module pwu_irq
   import pwu_pkg::*;
#(
   parameter int W = 8
) (
   input  wire logic         clk_i,    // system clock
   input  wire logic         rst_n_i,  // async reset, low
   input  wire logic [W-1:0] ev_i,     // event pulses
   input  wire logic         en_we_i,  // enable write
   input  wire logic         clr_we_i, // clear write
   input  wire logic [W-1:0] wdata_i,  // write data
   output logic [W-1:0]      sts_o,    // sticky status
   output logic [W-1:0]      en_o,     // enable mask
   output logic              irq_o     // level, registered
);
   // set wins over a clear in the same cycle
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sts_o <= '0;
      end else begin
         sts_o <= (sts_o & ~(clr_we_i ? wdata_i : '0)) | ev_i;
      end
   end

   // mask register
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         en_o <= '0;
      end else if (en_we_i) begin
         en_o <= wdata_i;
      end
   end

   // only enabled events interrupt
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         irq_o <= 1'b0;
      end else begin
         irq_o <= |(sts_o & en_o);
      end
   end
endmodule // pwu_irq

//--- hdl/pwu_top.sv
// pwu_top: double-buffered parameter update for a multi-channel pwm
// assumes a one-cycle strobe register port; fault pins are asynchronous
//
// The address-and-strobe port and the address map are this design's own decisions.
`timescale 1ns/1ps
module pwu_top
   import pwu_pkg::*;
#(
   parameter int NCH = PWU_NCH
) (
   input  wire logic              MCLK_I,   // system clock
   input  wire logic              RST_N_I,  // async reset, low
   input  wire logic [PWU_AW-1:0] ADDR_I,   // byte address
   input  wire logic [PWU_DW-1:0] WDATA_I,  // write data
   input  wire logic              WR_I,     // write strobe
   input  wire logic              RD_I,     // read strobe
   input  wire logic [NCH-1:0]    FAULT_I,  // fault pins, async
   output logic [PWU_DW-1:0]      RDATA_O,  // read data
   output logic [NCH-1:0]         PWMH_O,   // high side outputs
   output logic [NCH-1:0]         PWML_O,   // low side outputs
   output logic                   IRQ_O     // interrupt level
);
   // control state
   logic [NCH-1:0]       ena_r;
   logic [NCH-1:0]       scm_sync_r;
   pwu_sync_update_method_t            sync_update_method_r;
   logic                 unlock_r;
   logic [PWU_UPR_W-1:0] upr_r;
   logic [PWU_UPR_W-1:0] update_period_counter_r;

   // fault synchronisers
   logic [NCH-1:0]       flt1_r;
   logic [NCH-1:0]       flt2_r;
   logic [NCH-1:0]       flt3_r;

   // per-channel wires
   logic [NCH-1:0]       end_v;
   logic [NCH-1:0]       hi_v;
   logic [NCH-1:0]       lo_v;
   logic [NCH-1:0]       hit_v;
   logic [PWU_DW-1:0]    ch_rd [NCH];
   logic [NCH-1:0]       pend_prd;
   logic [NCH-1:0]       pend_dty;
   logic [NCH-1:0]       pend_dt;

   // sync update points
   logic                 end0;
   logic                 sync_pd_pt;
   logic                 sync_dty_pt;
   logic                 upr_wrap;
   logic                 any_sync_dty;

   // interrupt groups
   logic [PWU_IRQ1_W-1:0] ev1;
   logic [PWU_IRQ2_W-1:0] ev2;
   logic [PWU_IRQ1_W-1:0] sts1;
   logic [PWU_IRQ1_W-1:0] en1;
   logic [PWU_IRQ2_W-1:0] sts2;
   logic [PWU_IRQ2_W-1:0] en2;
   logic                  irq1;
   logic                  irq2;
   logic [PWU_DW-1:0]     rd_nxt;

   // register write decodes
   logic wr_ena;
   logic wr_dis;
   logic wr_scm;
   logic wr_scuc;
   logic wr_scup;

   assign wr_ena  = WR_I && (ADDR_I == PWU_ENA_OFF);
   assign wr_dis  = WR_I && (ADDR_I == PWU_DIS_OFF);
   assign wr_scm  = WR_I && (ADDR_I == PWU_SCM_OFF);
   assign wr_scuc = WR_I && (ADDR_I == PWU_SCUC_OFF);
   assign wr_scup = WR_I && (ADDR_I == PWU_SCUP_OFF);

   // channel enable and disable
   always_ff @(posedge MCLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         ena_r <= '0;
      end else if (wr_ena) begin
         ena_r <= ena_r | WDATA_I[NCH-1:0];
      end else if (wr_dis) begin
         ena_r <= ena_r & ~WDATA_I[NCH-1:0];
      end
   end

   // sync membership and update method
   always_ff @(posedge MCLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         scm_sync_r <= '0;
         sync_update_method_r     <= PWU_UPD_MANUAL;
      end else if (wr_scm) begin
         scm_sync_r <= WDATA_I[NCH-1:0];
         sync_update_method_r     <= pwu_sync_update_method_t'(WDATA_I[PWU_SYNC_UPDATE_METHOD_LSB +: 2]);
      end
   end

   // sync channels take updates on channel 0 period boundaries
   assign end0        = end_v[0];
   assign upr_wrap    = (update_period_counter_r == upr_r);
   assign sync_pd_pt  = end0 && unlock_r;
   assign sync_dty_pt = (sync_update_method_r == PWU_UPD_MANUAL) ? sync_pd_pt
                                                   : (end0 && upr_wrap);

   // unlock: a fresh write wins over the hardware clear
   always_ff @(posedge MCLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         unlock_r <= 1'b0;
      end else if (wr_scuc && WDATA_I[PWU_UNLOCK_BIT]) begin
         unlock_r <= 1'b1;
      end else if (end0) begin
         unlock_r <= 1'b0;
      end
   end

   // update period setting
   always_ff @(posedge MCLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         upr_r <= '0;
      end else if (wr_scup) begin
         upr_r <= WDATA_I[PWU_UPR_W-1:0];
      end
   end

   // update period counter, counts channel 0 periods
   always_ff @(posedge MCLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         update_period_counter_r <= '0;
      end else if (wr_scup) begin
         update_period_counter_r <= '0;
      end else if (end0) begin
         update_period_counter_r <= upr_wrap ? '0 : update_period_counter_r + 1'b1;
      end
   end

   // per-channel shadow, pending and active parameters
   genvar gi;
   generate
      for (gi = 0; gi < NCH; gi++) begin : g_ch
         localparam logic [7:0] BASE = PWU_CH_BASE + 8'(gi) * PWU_CH_STEP;
         pwu_prm_t shd_r;
         pwu_prm_t act_r;
         logic     wr_prd;
         logic     wr_dty;
         logic     wr_dt;
         logic     pt_pd;
         logic     pt_dty;

         assign wr_prd = WR_I && (ADDR_I == BASE + PWU_PRD_OFF);
         assign wr_dty = WR_I && (ADDR_I == BASE + PWU_DTY_OFF);
         assign wr_dt  = WR_I && (ADDR_I == BASE + PWU_DT_OFF);
         assign hit_v[gi] = (ADDR_I == BASE + PWU_PRD_OFF)
                          || (ADDR_I == BASE + PWU_DTY_OFF)
                          || (ADDR_I == BASE + PWU_DT_OFF);

         // application points; a stopped channel takes values at once
         always_comb begin
            if (!ena_r[gi]) begin
               pt_pd  = 1'b1;
               pt_dty = 1'b1;
            end else if (scm_sync_r[gi]) begin
               pt_pd  = sync_pd_pt;
               pt_dty = sync_dty_pt;
            end else begin
               pt_pd  = end_v[gi];
               pt_dty = end_v[gi];
            end
         end

         // shadows keep the last write only
         always_ff @(posedge MCLK_I or negedge RST_N_I) begin
            if (!RST_N_I) begin
               shd_r <= '{PWU_PRM_RST, PWU_PRM_RST, PWU_PRM_RST};
            end else begin
               if (wr_prd) shd_r.prd <= WDATA_I[PWU_CW-1:0];
               if (wr_dty) shd_r.dty <= WDATA_I[PWU_CW-1:0];
               if (wr_dt)  shd_r.dt  <= WDATA_I[PWU_CW-1:0];
            end
         end

         // pending flags; a write in the apply cycle stays pending
         always_ff @(posedge MCLK_I or negedge RST_N_I) begin
            if (!RST_N_I) begin
               pend_prd[gi] <= 1'b0;
               pend_dty[gi] <= 1'b0;
               pend_dt[gi]  <= 1'b0;
            end else begin
               pend_prd[gi] <= wr_prd || (pend_prd[gi] && !pt_pd);
               pend_dty[gi] <= wr_dty || (pend_dty[gi] && !pt_dty);
               pend_dt[gi]  <= wr_dt  || (pend_dt[gi]  && !pt_pd);
            end
         end

         // all due values move on one edge
         always_ff @(posedge MCLK_I or negedge RST_N_I) begin
            if (!RST_N_I) begin
               act_r <= '{PWU_PRM_RST, PWU_PRM_RST, PWU_PRM_RST};
            end else begin
               if (pend_prd[gi] && pt_pd)  act_r.prd <= shd_r.prd;
               if (pend_dty[gi] && pt_dty) act_r.dty <= shd_r.dty;
               if (pend_dt[gi]  && pt_pd)  act_r.dt  <= shd_r.dt;
            end
         end

         // active values read back
         always_comb begin
            ch_rd[gi] = '0;
            if (ADDR_I == BASE + PWU_PRD_OFF) begin
               ch_rd[gi][PWU_CW-1:0] = act_r.prd;
            end else if (ADDR_I == BASE + PWU_DTY_OFF) begin
               ch_rd[gi][PWU_CW-1:0] = act_r.dty;
            end else if (ADDR_I == BASE + PWU_DT_OFF) begin
               ch_rd[gi][PWU_CW-1:0] = act_r.dt;
            end
         end

         pwu_cnt #(
            .CW      (PWU_CW)
         ) u_cnt (
            .clk_i   (MCLK_I),
            .rst_n_i (RST_N_I),
            .en_i    (ena_r[gi]),
            .prm_i   (act_r),
            .end_o   (end_v[gi]),
            .hi_o    (hi_v[gi]),
            .lo_o    (lo_v[gi])
         );
      end
   endgenerate

   // fault pins through two flops, then edge detect
   always_ff @(posedge MCLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         flt1_r <= '0;
         flt2_r <= '0;
         flt3_r <= '0;
      end else begin
         flt1_r <= FAULT_I;
         flt2_r <= flt1_r;
         flt3_r <= flt2_r;
      end
   end

   // event vectors of both interrupt groups
   assign any_sync_dty = |(pend_dty & scm_sync_r & ena_r);
   always_comb begin
      ev1 = '0;
      ev1[NCH-1:0] = end_v;
      ev1[PWU_FAULT_LSB +: NCH] = flt2_r & ~flt3_r;
      ev2 = '0;
      ev2[PWU_WRITE_READY_FLAG_BIT] = sync_pd_pt || (sync_dty_pt && (sync_update_method_r != PWU_UPD_MANUAL));
      ev2[PWU_UNDERRUN_FLAG_BIT] = end0 && upr_wrap && (sync_update_method_r != PWU_UPD_MANUAL) && !any_sync_dty;
   end

   pwu_irq #(
      .W        (PWU_IRQ1_W)
   ) u_irq1 (
      .clk_i    (MCLK_I),
      .rst_n_i  (RST_N_I),
      .ev_i     (ev1),
      .en_we_i  (WR_I && (ADDR_I == PWU_IEN1_OFF)),
      .clr_we_i (WR_I && (ADDR_I == PWU_ICL1_OFF)),
      .wdata_i  (WDATA_I),
      .sts_o    (sts1),
      .en_o     (en1),
      .irq_o    (irq1)
   );

   pwu_irq #(
      .W        (PWU_IRQ2_W)
   ) u_irq2 (
      .clk_i    (MCLK_I),
      .rst_n_i  (RST_N_I),
      .ev_i     (ev2),
      .en_we_i  (WR_I && (ADDR_I == PWU_IEN2_OFF)),
      .clr_we_i (WR_I && (ADDR_I == PWU_ICL2_OFF)),
      .wdata_i  (WDATA_I[PWU_IRQ2_W-1:0]),
      .sts_o    (sts2),
      .en_o     (en2),
      .irq_o    (irq2)
   );

   // read data mux; unmapped reads as zero
   always_comb begin
      rd_nxt = '0;
      case (ADDR_I)
         PWU_CHSR_OFF: rd_nxt[NCH-1:0] = ena_r;
         PWU_SCM_OFF: begin
            rd_nxt[NCH-1:0] = scm_sync_r;
            rd_nxt[PWU_SYNC_UPDATE_METHOD_LSB +: 2] = sync_update_method_r;
         end
         PWU_SCUC_OFF: rd_nxt[PWU_UNLOCK_BIT] = unlock_r;
         PWU_SCUP_OFF: begin
            rd_nxt[PWU_UPR_W-1:0] = upr_r;
            rd_nxt[PWU_UPDATE_PERIOD_COUNTER_LSB +: PWU_UPR_W] = update_period_counter_r;
         end
         PWU_IEN1_OFF: rd_nxt = en1;
         PWU_IST1_OFF: rd_nxt = sts1;
         PWU_IEN2_OFF: rd_nxt[PWU_IRQ2_W-1:0] = en2;
         PWU_IST2_OFF: rd_nxt[PWU_IRQ2_W-1:0] = sts2;
         PWU_PEND_OFF: begin
            rd_nxt[NCH-1:0] = pend_prd;
            rd_nxt[PWU_PEND_DTY +: NCH] = pend_dty;
            rd_nxt[PWU_PEND_DT +: NCH] = pend_dt;
         end
         default: begin
            for (int i = 0; i < NCH; i++) begin
               if (hit_v[i]) rd_nxt = ch_rd[i];
            end
         end
      endcase
   end

   // read data stands one cycle after the strobe only
   always_ff @(posedge MCLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         RDATA_O <= '0;
      end else begin
         RDATA_O <= RD_I ? rd_nxt : '0;
      end
   end

   // output flops
   always_ff @(posedge MCLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         PWMH_O <= '0;
         PWML_O <= '0;
         IRQ_O  <= 1'b0;
      end else begin
         PWMH_O <= hi_v;
         PWML_O <= lo_v;
         IRQ_O  <= irq1 || irq2;
      end
   end
endmodule // pwu_top

//--- dv/pwu_top_chk.sv
// pwu_top_chk: port assertions for the pwm parameter update block
// assumes the one-cycle strobe register port and the offsets of pwu_pkg
`timescale 1ns/1ps
module pwu_top_chk
   import pwu_pkg::*;
#(
   parameter int NCH = PWU_NCH
) (
   input wire logic              MCLK_I,  // system clock
   input wire logic              RST_N_I, // async reset, low
   input wire logic [PWU_AW-1:0] ADDR_I,  // byte address
   input wire logic [PWU_DW-1:0] WDATA_I, // write data
   input wire logic              WR_I,    // write strobe
   input wire logic              RD_I,    // read strobe
   input wire logic [PWU_DW-1:0] RDATA_O, // read data
   input wire logic [NCH-1:0]    PWMH_O,  // high side
   input wire logic [NCH-1:0]    PWML_O,  // low side
   input wire logic              IRQ_O    // interrupt level
);
   logic [NCH-1:0]        en_r;    // enabled channels
   logic [NCH-1:0]        en_d1_r; // enable history, outputs lag it
   logic [NCH-1:0]        en_d2_r;
   logic [NCH-1:0]        en_d3_r;
   logic [PWU_DW-1:0]     ien1_r;  // first enable group
   logic [PWU_IRQ2_W-1:0] ien2_r;  // second enable group
   logic [NCH-1:0]        scm_r;   // sync membership
   logic [PWU_UPR_W-1:0]  upr_r;   // update period setting

   // mirror of the control writes
   always_ff @(posedge MCLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         en_r    <= '0;
         en_d1_r <= '0;
         en_d2_r <= '0;
         en_d3_r <= '0;
         ien1_r  <= '0;
         ien2_r  <= '0;
         scm_r   <= '0;
         upr_r   <= '0;
      end else begin
         en_d1_r <= en_r;
         en_d2_r <= en_d1_r;
         en_d3_r <= en_d2_r;
         if (WR_I && ADDR_I == PWU_ENA_OFF) en_r <= en_r | WDATA_I[NCH-1:0];
         else if (WR_I && ADDR_I == PWU_DIS_OFF) en_r <= en_r & ~WDATA_I[NCH-1:0];
         if (WR_I && ADDR_I == PWU_IEN1_OFF) ien1_r <= WDATA_I;
         if (WR_I && ADDR_I == PWU_IEN2_OFF) ien2_r <= WDATA_I[PWU_IRQ2_W-1:0];
         if (WR_I && ADDR_I == PWU_SCM_OFF) scm_r <= WDATA_I[NCH-1:0];
         if (WR_I && ADDR_I == PWU_SCUP_OFF) upr_r <= WDATA_I[PWU_UPR_W-1:0];
      end
   end

   default clocking cb @(posedge MCLK_I);
   endclocking
   default disable iff (!RST_N_I);

   property p_rd_idle;
      !$past(RD_I) |-> RDATA_O == '0;
   endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
   property p_off_quiet;
      ((PWMH_O | PWML_O) & ~(en_r | en_d1_r | en_d2_r | en_d3_r)) == '0;
   endproperty
   a_off_quiet: assert property (p_off_quiet) else $error("disabled channel active");
   property p_ena_read;
      $past(RD_I && ADDR_I == PWU_CHSR_OFF) |-> RDATA_O == PWU_DW'($past(en_r));
   endproperty
   a_ena_read: assert property (p_ena_read) else $error("enable status wrong");
   property p_ien1_read;
      $past(RD_I && ADDR_I == PWU_IEN1_OFF) |-> RDATA_O == $past(ien1_r);
   endproperty
   a_ien1_read: assert property (p_ien1_read) else $error("first enable wrong");
   property p_ien2_read;
      $past(RD_I && ADDR_I == PWU_IEN2_OFF) |-> RDATA_O == PWU_DW'($past(ien2_r));
   endproperty
   a_ien2_read: assert property (p_ien2_read) else $error("second enable wrong");
   property p_clr_read;
      $past(RD_I && (ADDR_I == PWU_ICL1_OFF || ADDR_I == PWU_ICL2_OFF)) |-> RDATA_O == '0;
   endproperty
   a_clr_read: assert property (p_clr_read) else $error("clear register readable");
   property p_irq_mask;
      (ien1_r == '0 && ien2_r == '0) [*3] |-> !IRQ_O;
   endproperty
   a_irq_mask: assert property (p_irq_mask) else $error("interrupt while masked");
   property p_upr_bound;
      $past(RD_I && ADDR_I == PWU_SCUP_OFF)
         |-> RDATA_O[PWU_UPDATE_PERIOD_COUNTER_LSB +: PWU_UPR_W] <= $past(upr_r);
   endproperty
   a_upr_bound: assert property (p_upr_bound) else $error("update count too big");
   property p_scm_read;
      $past(RD_I && ADDR_I == PWU_SCM_OFF) |-> RDATA_O[NCH-1:0] == $past(scm_r);
   endproperty
   a_scm_read: assert property (p_scm_read) else $error("sync bits wrong");
endmodule // pwu_top_chk

bind pwu_top pwu_top_chk #(.NCH(NCH)) i_chk (
   .MCLK_I(MCLK_I), .RST_N_I(RST_N_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I),
   .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O), .PWMH_O(PWMH_O),
   .PWML_O(PWML_O), .IRQ_O(IRQ_O)
);

//--- dv/pwu_top_test.sv
// pwu_top_test: self-checking bench for the pwm parameter update block
// assumes pwu_pkg offsets, a 25 MHz clock and the one-cycle strobe port
`timescale 1ns/1ps
`define CHK(got, exp) \
   begin \
      num_checks++; \
      if ((got) !== (exp)) begin \
         fails++; \
         $display("CHECK FAILED at %0t: got %h expected %h", $time, (got), (exp)); \
      end \
   end
module pwu_top_test;
   import pwu_pkg::*;
   localparam int NCH = PWU_NCH;
   logic              mclk    = 1'b0;
   logic              rst_n   = 1'b0;
   logic [PWU_AW-1:0] addr    = '0;
   logic [PWU_DW-1:0] wdata   = '0;
   logic              wr      = 1'b0;
   logic              rd      = 1'b0;
   logic [NCH-1:0]    fault   = '0;
   logic [PWU_DW-1:0] rdata;
   logic [NCH-1:0]    pwmh;
   logic [NCH-1:0]    pwml;
   logic              irq;
   logic              rd_seen = 1'b0;
   logic [PWU_DW-1:0] exp_q[$];
   logic [PWU_DW-1:0] msk_q[$];
   logic [PWU_DW-1:0] e;
   logic [PWU_DW-1:0] m;
   logic [15:0]       seed    = 16'hB8BB; // 47291
   logic [15:0]       d;
   int                fails   = 0;
   int                num_checks = 0;

   // 25 MHz system clock
   always #20 mclk = ~mclk;

   pwu_top #(.NCH(NCH)) i_dut (
      .MCLK_I(mclk), .RST_N_I(rst_n), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr),
      .RD_I(rd), .FAULT_I(fault), .RDATA_O(rdata), .PWMH_O(pwmh), .PWML_O(pwml),
      .IRQ_O(irq)
   );

   // result side: the oldest note is compared in the cycle after the strobe
   always @(posedge mclk) rd_seen <= rd;
   always @(negedge mclk) begin
      if (rd_seen && exp_q.size() > 0) begin
         m = msk_q.pop_front();
         e = exp_q.pop_front();
         `CHK(rdata & m, e)
      end
   end

   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction

   function automatic logic [7:0] chad(input int ch, input logic [7:0] off);
      return PWU_CH_BASE + 8'(ch) * PWU_CH_STEP + off;
   endfunction

   task automatic conclude();
      $display("comparisons %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   task automatic wr_reg(input logic [7:0] a, input logic [31:0] dat);
      @(posedge mclk);
      addr  <= a;
      wdata <= dat;
      wr    <= 1'b1;
      @(posedge mclk);
      wr    <= 1'b0;
   endtask

   // read: the expectation is noted when the strobe goes out
   task automatic rd_reg(input logic [7:0] a, input logic [31:0] ex, input logic [31:0] mk);
      @(posedge mclk);
      addr <= a;
      rd   <= 1'b1;
      exp_q.push_back(ex & mk);
      msk_q.push_back(mk);
      @(posedge mclk);
      rd   <= 1'b0;
   endtask

   task automatic set_prm(input int ch, input logic [15:0] p, input logic [15:0] dy,
                          input logic [15:0] t);
      wr_reg(chad(ch, PWU_PRD_OFF), {16'h0000, p});
      wr_reg(chad(ch, PWU_DTY_OFF), {16'h0000, dy});
      wr_reg(chad(ch, PWU_DT_OFF), {16'h0000, t});
   endtask

   // bounded wait for the start of a high pulse
   task automatic wait_rise(input int ch);
      int n;
      for (n = 0; n < 2000 && pwmh[ch] !== 1'b0; n++) @(negedge mclk);
      while (n < 2000 && pwmh[ch] !== 1'b1) begin
         @(negedge mclk);
         n++;
      end
      if (n >= 2000) begin
         fails++;
         conclude();
      end
   endtask

   // count high and low side cycles over one period from a rising edge
   task automatic measure(input int ch, input int p, input logic [15:0] eh,
                          input logic [15:0] el);
      logic [15:0] h;
      logic [15:0] l;
      h = '0;
      l = '0;
      wait_rise(ch);
      repeat (p) begin
         h = h + pwmh[ch];
         l = l + pwml[ch];
         @(negedge mclk);
      end
      `CHK(h, eh)
      `CHK(l, el)
   endtask

   initial begin
      repeat (5) @(posedge mclk);
      rst_n <= 1'b1;
      // reset state and quiet reads
      rd_reg(PWU_CHSR_OFF, 32'h0, '1);
      rd_reg(PWU_PEND_OFF, 32'h0, '1);
      rd_reg(8'h34, 32'h0, '1);
      rd_reg(PWU_ICL1_OFF, 32'h0, '1);
      rd_reg(chad(0, PWU_PRD_OFF), {16'h0000, PWU_PRM_RST}, '1);
      // asynchronous channel 1 started by its enable bit
      set_prm(1, 16'h0014, 16'h0008, 16'h0001);
      wr_reg(PWU_ENA_OFF, 32'h2);
      rd_reg(PWU_CHSR_OFF, 32'h2, '1);
      measure(1, 20, 16'h0007, 16'h000B);
      // running: shadows wait for the period end, last write wins
      wait_rise(1);
      wr_reg(chad(1, PWU_PRD_OFF), 32'h30);
      set_prm(1, 16'h000C, 16'h0005, 16'h0001);
      rd_reg(chad(1, PWU_PRD_OFF), 32'h14, '1);
      rd_reg(PWU_PEND_OFF, 32'h00020202, 32'h00020202);
      repeat (2) wait_rise(1);
      rd_reg(chad(1, PWU_PRD_OFF), 32'hC, '1);
      rd_reg(chad(1, PWU_DTY_OFF), 32'h5, '1);
      rd_reg(PWU_PEND_OFF, 32'h0, 32'h00020202);
      // random duties, one count steps
      repeat (4) begin
         seed = lfsr(seed);
         d = 16'h0002 + (seed % 16'h0009);
         wr_reg(chad(1, PWU_DTY_OFF), {16'h0000, d});
         repeat (2) wait_rise(1);
         measure(1, 12, d - 16'h0001, 16'h000B - d);
      end
      // sync channel 0, method zero: held until unlock
      set_prm(0, 16'h000A, 16'h0004, 16'h0001);
      wr_reg(PWU_SCM_OFF, 32'h1);
      rd_reg(PWU_SCM_OFF, 32'h1, 32'h0003000F);
      wr_reg(PWU_ENA_OFF, 32'h1);
      wr_reg(PWU_IEN2_OFF, 32'h1);
      set_prm(0, 16'h0010, 16'h0006, 16'h0002);
      repeat (3) wait_rise(0);
      rd_reg(chad(0, PWU_PRD_OFF), 32'hA, '1);
      wr_reg(PWU_SCUC_OFF, 32'h1);
      repeat (2) wait_rise(0);
      rd_reg(chad(0, PWU_PRD_OFF), 32'h10, '1);
      rd_reg(chad(0, PWU_DT_OFF), 32'h2, '1);
      rd_reg(PWU_SCUC_OFF, 32'h0, 32'h1);
      @(negedge mclk);
      `CHK(irq, 1'b1)
      rd_reg(PWU_IST2_OFF, 32'h1, 32'h1);
      rd_reg(PWU_IEN2_OFF, 32'h1, '1);
      wr_reg(PWU_ICL2_OFF, 32'h1);
      wr_reg(PWU_IEN2_OFF, 32'h0);
      repeat (3) @(negedge mclk);
      `CHK(irq, 1'b0)
      // method one: duty follows the update period, period needs unlock
      wr_reg(PWU_SCM_OFF, 32'h00010001);
      wr_reg(PWU_SCUP_OFF, 32'h2);
      set_prm(0, 16'h000C, 16'h0003, 16'h0002);
      rd_reg(chad(0, PWU_DTY_OFF), 32'h6, '1);
      repeat (5) wait_rise(0);
      rd_reg(chad(0, PWU_DTY_OFF), 32'h3, '1);
      rd_reg(chad(0, PWU_PRD_OFF), 32'h10, '1);
      rd_reg(PWU_SCUP_OFF, 32'h2, 32'hF);
      wr_reg(PWU_SCUC_OFF, 32'h1);
      repeat (2) wait_rise(0);
      rd_reg(chad(0, PWU_PRD_OFF), 32'hC, '1);
      // fault status: one enabled, one masked
      wr_reg(PWU_IEN1_OFF, 32'h00040000);
      rd_reg(PWU_IEN1_OFF, 32'h00040000, '1);
      @(posedge mclk);
      fault <= 4'h8;
      repeat (6) @(negedge mclk);
      `CHK(irq, 1'b0)
      @(posedge mclk);
      fault <= 4'hC;
      repeat (6) @(negedge mclk);
      `CHK(irq, 1'b1)
      rd_reg(PWU_IST1_OFF, 32'h000C0000, 32'h000F0000);
      wr_reg(PWU_ICL1_OFF, 32'h00040000);
      repeat (3) @(negedge mclk);
      `CHK(irq, 1'b0)
      rd_reg(PWU_IST1_OFF, 32'h00080000, 32'h000F0000);
      // stop everything
      wr_reg(PWU_DIS_OFF, 32'hF);
      rd_reg(PWU_CHSR_OFF, 32'h0, '1);
      repeat (5) @(negedge mclk);
      `CHK({pwmh, pwml}, 8'h00)
      conclude();
   end
endmodule // pwu_top_test
